// ---- rtl/sxmc_core.sv ----
`timescale 1ns/1ps

// Behaviour
// - Speed select picks upper or lower serial range
// - Speed, prescale, width set synthesizer ratios
// - Prescale low passes reference clock straight through
// - Prescale high halves reference before multiplier
// - Bypass, prescale, low speed: full flag toggles
// - Queue bypass is only passed out and enables toggling; both buffers stay in the path
// - 8-bit coded: capture data byte or command nibble
// - 8-bit coded: receive on data byte or nibble
// - 8-bit raw: ten-bit characters to receive outputs
// - 10-bit coded: capture ten data or two command
// - 10-bit coded: receive on ten data or two
// - 10-bit raw: twelve bits across data and command
// - Codec bypass low skips encode and decode
module sxmc_core
	import sxmc_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	// Host transmit side
	input  wire logic [9:0]          tx_parallel_bus,
	input  wire logic [3:0]          tx_command_bus,
	input  wire logic                tx_char_type_select,
	input  wire logic                tx_valid,
	output logic                     tx_ready,
	output logic                     tx_queue_full_flag,
	// Host receive side
	output logic      [9:0]          rx_parallel_bus,
	output logic      [3:0]          rx_command_bus,
	output logic                     rx_char_type_flag,
	output logic                     rx_valid,
	input  wire logic                rx_ready,
	// Toward the encoder and serializer
	output logic      [CHAR_W-1:0]   enc_char,
	output logic                     enc_type,
	output logic                     enc_valid,
	input  wire logic                enc_ready,
	// From the decoder and deserializer
	input  wire logic [CHAR_W-1:0]   dec_char,
	input  wire logic                dec_type,
	input  wire logic                dec_valid,
	output logic                     dec_ready,
	// Static mode toward the serial side
	output logic                     upper_range,
	output logic      [7:0]          synth_multiplier,
	output logic      [1:0]          synth_divider,
	output logic                     pll_ref_enable,
	output logic                     queue_bypass,
	output logic                     char_width_8,
	output logic                     codec_bypass
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	sxmc_state_type st;
	sxmc_state_type next_st;

	logic           speed_sel;
	logic           prescale_sel;
	logic           qbyp_sel;
	logic           width8_sel;
	logic           codec_on;
	logic           toggle_mode;
	logic           bus_req;
	logic           hit_ctrl;
	logic           hit_status;
	logic           tx_take;
	logic           enc_take;
	logic           dec_take;
	logic           rx_take;
	sxmc_entry_type tx_word;
	sxmc_entry_type rx_head;
	logic [31:0]    status_word;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// Static selects straight from the control register
	assign speed_sel    = st.ctrl[BIT_SPEED];
	assign prescale_sel = st.ctrl[BIT_PRESCALE];
	assign qbyp_sel     = st.ctrl[BIT_QBYP];
	assign width8_sel   = st.ctrl[BIT_WIDTH8];
	assign codec_on     = st.ctrl[BIT_CODEC_N];  // Low means bypass

	// Range and synthesizer ratios; the mode is not resynchronised,
	// so software must reset after a change
	assign upper_range  = speed_sel;
	// Multiplier is the bits of one internal character,
	// doubled in the upper range
	always_comb
	begin
		unique case ({speed_sel, width8_sel})
			2'b01: synth_multiplier = CODED_W8;                   // Lower range
			2'b00: synth_multiplier = CODED_W10;                  // Lower range
			2'b11: synth_multiplier = {CODED_W8[6:0], 1'b0};      // Upper range
			2'b10: synth_multiplier = {CODED_W10[6:0], 1'b0};     // Upper range
		endcase
	end

	// Divider follows the prescaler
	always_comb
	begin
		if (prescale_sel)
			synth_divider = 2'h2;
		else
			synth_divider = 2'h1;
	end

	// Reference enable: every cycle, or every other cycle when halved;
	// an enable pulse instead of a divided clock keeps one clock domain
	always_comb
	begin
		if (prescale_sel)
			pll_ref_enable = st.ref_phase;
		else
			pll_ref_enable = 1'b1;
	end

	assign queue_bypass = qbyp_sel;
	assign char_width_8 = width8_sel;
	assign codec_bypass = ~codec_on;

	// Character-rate toggling only in this one combination
	assign toggle_mode = qbyp_sel & prescale_sel & ~speed_sel;

	// ------------------------------------------------------------
	// Transmit capture
	// ------------------------------------------------------------
	// Pack the host character by width and codec mode
	always_comb
	begin
		tx_word = '0;
		if (width8_sel && codec_on)
		begin
			tx_word[CHAR_W] = tx_char_type_select;
			if (tx_char_type_select)
				tx_word[3:0] = tx_command_bus;
			else
				tx_word[7:0] = tx_parallel_bus[7:0];
		end
		else if (width8_sel)
		begin
			tx_word[9:0] = tx_parallel_bus;  // Raw ten-bit character
		end
		else if (codec_on)
		begin
			tx_word[CHAR_W] = tx_char_type_select;
			if (tx_char_type_select)
				tx_word[1:0] = tx_command_bus[1:0];
			else
				tx_word[9:0] = tx_parallel_bus;
		end
		else
		begin
			tx_word[11:0] = {tx_command_bus[1:0], tx_parallel_bus};
		end
	end

	// In the toggling mode input is taken only in the low half
	assign tx_ready = (st.tx_cnt != BUF_DEPTH) & ~(toggle_mode & st.full_tgl);
	assign tx_take  = tx_valid & tx_ready;

	// Full flag: buffer level normally, a character-rate square wave in
	// the toggling mode so the host can pace itself without a counter
	always_comb
	begin
		if (toggle_mode)
			tx_queue_full_flag = st.full_tgl;
		else
			tx_queue_full_flag = (st.tx_cnt == BUF_DEPTH);
	end

	// Head of the transmit buffer toward the encoder
	// Character stands until the encoder takes it
	assign enc_valid = (st.tx_cnt != 2'h0);
	assign enc_char  = st.tx_mem[st.tx_rd][CHAR_W-1:0];
	assign enc_type  = st.tx_mem[st.tx_rd][CHAR_W];
	assign enc_take  = enc_valid & enc_ready;

	// ------------------------------------------------------------
	// Receive presentation
	// ------------------------------------------------------------
	assign dec_ready = (st.rx_cnt != BUF_DEPTH);
	assign dec_take  = dec_valid & dec_ready;
	assign rx_valid  = (st.rx_cnt != 2'h0);
	assign rx_take   = rx_valid & rx_ready;
	assign rx_head   = st.rx_mem[st.rx_rd];

	// Unpack by mode; lanes that the mode does not use read zero
	// Raw modes carry no type, so the flag reads zero there
	always_comb
	begin
		rx_parallel_bus   = '0;
		rx_command_bus    = '0;
		rx_char_type_flag = 1'b0;
		if (width8_sel && codec_on)
		begin
			rx_char_type_flag = rx_head[CHAR_W];
			if (rx_head[CHAR_W])
				rx_command_bus = rx_head[3:0];
			else
				rx_parallel_bus[7:0] = rx_head[7:0];
		end
		else if (width8_sel)
		begin
			rx_parallel_bus = rx_head[9:0];
		end
		else if (codec_on)
		begin
			rx_char_type_flag = rx_head[CHAR_W];
			if (rx_head[CHAR_W])
				rx_command_bus[1:0] = rx_head[1:0];
			else
				rx_parallel_bus = rx_head[9:0];
		end
		else
		begin
			rx_parallel_bus     = rx_head[9:0];
			rx_command_bus[1:0] = rx_head[11:10];
		end
	end

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	assign bus_req  = wb_cyc_i & wb_stb_i;
	assign wb_ack_o = (st.bus == BUS_ACK);
	assign wb_dat_o = st.dat;

	// Address decode; other offsets read zero and ignore writes
	assign hit_ctrl   = (wb_adr_i == ADR_CTRL);
	assign hit_status = (wb_adr_i == ADR_STATUS);

	// Live view of the block for software
	always_comb
	begin
		status_word = '0;
		status_word[ST_MULT_LSB +: 8]  = synth_multiplier;
		status_word[ST_DIV_LSB +: 2]   = synth_divider;
		status_word[ST_TXCNT_LSB +: 2] = st.tx_cnt;
		status_word[ST_RXCNT_LSB +: 2] = st.rx_cnt;
		status_word[ST_FULL]           = tx_queue_full_flag;
		status_word[ST_REFPH]          = st.ref_phase;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;

		// Divider phase runs free; only its use is gated by the prescaler
		next_st.ref_phase = ~st.ref_phase;

		// Character-rate flag starts low, so the first cycle of the
		// toggling mode accepts input
		if (toggle_mode)
			next_st.full_tgl = ~st.full_tgl;
		else
			next_st.full_tgl = 1'b0;

		// One request answered one cycle later, dropped the next
		unique case (st.bus)
			BUS_IDLE:
			begin
				next_st.dat = '0;
				if (bus_req)
				begin
					next_st.bus = BUS_ACK;
					if (!wb_we_i && hit_ctrl)
						next_st.dat[CTRL_W-1:0] = st.ctrl;
					else if (!wb_we_i && hit_status)
						next_st.dat = status_word;
					// Write lands in the edge that shows ack; only byte lane 0
					// holds control bits, so other lanes alone change nothing
					if (wb_we_i && wb_sel_i[0] && hit_ctrl)
						next_st.ctrl = wb_dat_i[CTRL_W-1:0];
				end
			end
			BUS_ACK:
			begin
				// Read data stands with ack only
				next_st.bus = BUS_IDLE;
				next_st.dat = '0;
			end
		endcase

		// Transmit buffer: write and read may share a cycle
		// and then the count holds; a full buffer refuses input even in a cycle it is read
		if (tx_take)
		begin
			next_st.tx_mem[st.tx_wr] = tx_word;
			next_st.tx_wr = ~st.tx_wr;
		end
		if (enc_take)
			next_st.tx_rd = ~st.tx_rd;
		next_st.tx_cnt = st.tx_cnt + {1'b0, tx_take} - {1'b0, enc_take};

		// Receive buffer; a stall by the host loses no character
		if (dec_take)
		begin
			next_st.rx_mem[st.rx_wr] = {dec_type, dec_char};
			next_st.rx_wr = ~st.rx_wr;
		end
		if (rx_take)
			next_st.rx_rd = ~st.rx_rd;
		next_st.rx_cnt = st.rx_cnt + {1'b0, dec_take} - {1'b0, rx_take};
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Reset clears all but the bus state and the mode, which loads CTRL_RESET; one clock of reset is enough
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			// Empty buffers, idle bus, flag and phase low
			st           <= '0;
			st.bus       <= BUS_IDLE;
			// Mode returns to its default, so a host that changed it
			// must write it again after reset
			st.ctrl      <= CTRL_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end

endmodule

// ---- rtl/sxmc_pkg.sv ----
package sxmc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;

	// Control register field positions
	localparam int BIT_SPEED    = 0;  // speed_range_select
	localparam int BIT_PRESCALE = 1;  // pll_reference_clock_prescale_select
	localparam int BIT_QBYP     = 2;  // queue_bypass_select
	localparam int BIT_WIDTH8   = 3;  // char_width_select, high = 8-bit
	localparam int BIT_CODEC_N  = 4;  // codec_bypass_select, low = bypass
	localparam int CTRL_W       = 5;

	// 8-bit width with the codec in use after reset
	localparam logic [4:0] CTRL_RESET = 5'h18;

	// Status register field positions
	localparam int ST_MULT_LSB  = 0;   // 8 bits
	localparam int ST_DIV_LSB   = 8;   // 2 bits
	localparam int ST_TXCNT_LSB = 10;  // 2 bits
	localparam int ST_RXCNT_LSB = 12;  // 2 bits
	localparam int ST_FULL      = 14;
	localparam int ST_REFPH     = 15;

	// ------------------------------------------------------------
	// Character path
	// ------------------------------------------------------------
	localparam int CHAR_W       = 12;
	localparam logic [7:0] CODED_W8  = 8'h0a;  // internal char bits, 8-bit mode
	localparam logic [7:0] CODED_W10 = 8'h0c;  // internal char bits, 10-bit mode
	localparam logic [1:0] BUF_DEPTH = 2'h2;

	// Bus slave states, one-hot
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} sxmc_bus_type;

	// Buffer entry: character type on top, character below
	typedef logic [CHAR_W:0] sxmc_entry_type;

	typedef struct packed {
		sxmc_bus_type          bus;
		logic [CTRL_W-1:0]     ctrl;
		logic [31:0]           dat;
		logic                  ref_phase;
		logic                  full_tgl;
		sxmc_entry_type [1:0]  tx_mem;
		logic                  tx_wr;
		logic                  tx_rd;
		logic [1:0]            tx_cnt;
		sxmc_entry_type [1:0]  rx_mem;
		logic                  rx_wr;
		logic                  rx_rd;
		logic [1:0]            rx_cnt;
	} sxmc_state_type;

endpackage

// ---- verif/serial_xcvr_mode_config_tb_top.sv ----
`timescale 1ns/1ps

module serial_xcvr_mode_config_tb_top;
	import sxmc_pkg::*;
	logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_char_type_select, tx_valid;
	logic tx_ready, tx_queue_full_flag, rx_char_type_flag, rx_valid, rx_ready, enc_type;
	logic enc_valid, enc_ready, dec_type, dec_valid, dec_ready, upper_range, pll_ref_enable;
	logic queue_bypass, char_width_8, codec_bypass, hold, w8, cod, sp, t, ph;
	logic [7:0]        wb_adr_i, synth_multiplier;
	logic [3:0]        wb_sel_i, tx_command_bus, rx_command_bus, c;
	logic [31:0]       wb_dat_i, wb_dat_o, rd;
	logic [9:0]        tx_parallel_bus, rx_parallel_bus, d;
	logic [CHAR_W-1:0] enc_char, dec_char;
	logic [1:0]        synth_divider;
	logic [12:0]       exp_q [$];
	int                err_count, check_count, cyc_cnt;

	sxmc_core i_dut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_parallel_bus, .tx_command_bus, .tx_char_type_select,
		.tx_valid, .tx_ready, .tx_queue_full_flag, .rx_parallel_bus, .rx_command_bus,
		.rx_char_type_flag, .rx_valid, .rx_ready, .enc_char, .enc_type, .enc_valid, .enc_ready,
		.dec_char, .dec_type, .dec_valid, .dec_ready, .upper_range, .synth_multiplier,
		.synth_divider, .pll_ref_enable, .queue_bypass, .char_width_8, .codec_bypass);
	sxmc_serial_model i_far (.clk, .hold, .enc_char, .enc_type, .enc_valid, .enc_ready);

	// ----------------------------------------
	// Expectations and bus tasks
	// ----------------------------------------
	// Host character as it reaches the encoder: {type, char}
	function automatic logic [12:0] tx_exp(logic w8, cod, logic [9:0] d, logic [3:0] c, logic t);
		if (cod)
			return t ? {1'b1, 8'h0, w8 ? c : {2'h0, c[1:0]}} : {3'h0, w8 ? {2'h0, d[7:0]} : d};
		return {1'b0, w8 ? 2'h0 : c[1:0], d};
	endfunction
	// Received character at the host: {flag, command, data}
	function automatic logic [14:0] rx_exp(logic w8, cod, logic [9:0] d, logic [3:0] c, logic t);
		if (cod)
			return t ? {1'b1, w8 ? c : {2'h0, c[1:0]}, 10'h0} : {5'h0, w8 ? {2'h0, d[7:0]} : d};
		return {3'h0, w8 ? 2'h0 : c[1:0], d};
	endfunction
	task automatic chk(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (err_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Classic single cycle; held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, wd};
		@(posedge clk);
		while (wb_ack_o !== 1'b1) @(posedge clk);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
	endtask
	task automatic send();
		{d, c, t} = 15'($urandom);
		exp_q.push_back(tx_exp(w8, cod, d, c, t));
		@(posedge clk);
		{tx_parallel_bus, tx_command_bus, tx_char_type_select, tx_valid} <= {d, c, t, 1'b1};
		@(posedge clk);
		while (tx_ready !== 1'b1) @(posedge clk);
		tx_valid <= 1'b0;
	endtask
	task automatic enc_check();
		while (i_far.got.size() == 0) @(posedge clk);
		chk(32'(i_far.got.pop_front()), 32'(exp_q.pop_front()));
	endtask
	// Decoder pushes the same character back; host stalls a cycle
	task automatic rx_round();
		@(posedge clk);
		{dec_type, dec_char, dec_valid} <= {tx_exp(w8, cod, d, c, t), 1'b1};
		@(posedge clk);
		while (dec_ready !== 1'b1) @(posedge clk);
		dec_valid <= 1'b0;
		@(posedge clk);
		while (rx_valid !== 1'b1) @(posedge clk);
		chk({rx_char_type_flag, rx_command_bus, rx_parallel_bus}, rx_exp(w8, cod, d, c, t));
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
	endtask

	// ----------------------------------------
	// Clock, timeout and main sequence
	// ----------------------------------------
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			err_count++;
			complete_run();
		end
	end
	initial
	begin
		{clk, hold, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, rx_ready} = '0;
		{tx_parallel_bus, tx_command_bus, tx_char_type_select, tx_valid} = '0;
		{dec_char, dec_type, dec_valid} = '0;
		sys_rst = 1'b1;
		wb_sel_i = 4'hf;
		void'($urandom(53679));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		wb(0, ADR_CTRL, 0);
		chk(rd, 32'(CTRL_RESET));
		// Every width and codec combination, random speed range
		for (int m = 0; m < 4; m++)
		begin
			{cod, w8, sp} = {m[1:0], 1'($urandom)};
			wb(1, ADR_CTRL, {27'h0, cod, w8, 2'h0, sp});
			wb(0, ADR_STATUS, 0);
			chk(rd[9:0], {2'h1, 8'((w8 ? 10 : 12) << sp)});
			chk({upper_range, char_width_8}, {sp, w8});
			chk({codec_bypass, queue_bypass}, {!cod, 1'b0});
			repeat (3)
			begin
				send();
				enc_check();
				rx_round();
			end
		end
		// Stalled encoder: two entries, then refusal, then drain
		hold <= 1'b1;
		repeat (3) @(posedge clk);
		send();
		send();
		@(posedge clk);
		chk(tx_ready, 0);
		chk(tx_queue_full_flag, 1);
		hold <= 1'b0;
		enc_check();
		enc_check();
		// Mid-run reset with a character held: buffer empties, mode defaults
		hold <= 1'b1;
		send();
		exp_q.delete();
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		hold <= 1'b0;
		wb(0, ADR_STATUS, 0);
		chk(rd[14:0], {3'h0, 2'h0, 2'h1, CODED_W8});
		// Toggle mode: queue bypass, prescale, lower range
		wb(1, ADR_CTRL, 32'h1e);
		wb(0, ADR_STATUS, 0);
		chk(rd[9:0], {2'h2, 8'h0a});
		chk(queue_bypass, 1);
		@(posedge clk);
		ph = tx_queue_full_flag;
		@(posedge clk);
		chk(tx_queue_full_flag, !ph);
		send();
		enc_check();
		wb(1, ADR_STATUS, 0);
		wb(0, 8'h08, 0);
		chk(rd, 0);
		wb(0, ADR_CTRL, 0);
		chk(rd, 32'h1e);
		complete_run();
	end
endmodule

// ---- verif/sxmc_core_monitor.sv ----
`timescale 1ns/1ps

module sxmc_core_monitor
	import sxmc_pkg::*;
(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_ack_o,
	input wire logic              tx_valid,
	input wire logic              tx_ready,
	input wire logic              tx_queue_full_flag,
	input wire logic [CHAR_W-1:0] enc_char,
	input wire logic              enc_valid,
	input wire logic              enc_ready,
	input wire logic              upper_range,
	input wire logic [7:0]        synth_multiplier,
	input wire logic [1:0]        synth_divider,
	input wire logic              pll_ref_enable,
	input wire logic              queue_bypass,
	input wire logic              char_width_8
);
	// ----------------------------------------
	// Checks, all in the one clock domain
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// Toggle mode as seen from the serial-side levels
	wire tog = queue_bypass && synth_divider == 2'h2 && !upper_range;

	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_mult_ratio: assert property (synth_multiplier == ((char_width_8 ? 8'h0a : 8'h0c) << upper_range))
		else $error("bad multiplier");
	a_ref_direct: assert property (synth_divider == 2'h1 |-> pll_ref_enable)
		else $error("reference gated");
	a_ref_halved: assert property ((synth_divider == 2'h2) [*2] |-> pll_ref_enable != $past(pll_ref_enable))
		else $error("reference not halved");
	a_full_toggles: assert property (tog [*3] |-> tx_queue_full_flag != $past(tx_queue_full_flag))
		else $error("full flag stuck");
	a_tx_refused: assert property (tog && tx_queue_full_flag |-> !tx_ready)
		else $error("taken while full");
	a_enc_follows: assert property (tx_valid && tx_ready |=> enc_valid)
		else $error("char not forwarded");
	a_enc_held: assert property (enc_valid && !enc_ready |=> enc_valid && $stable(enc_char))
		else $error("stalled char lost");
endmodule

bind sxmc_core sxmc_core_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.tx_queue_full_flag(tx_queue_full_flag), .enc_char(enc_char), .enc_valid(enc_valid),
	.enc_ready(enc_ready), .upper_range(upper_range), .synth_multiplier(synth_multiplier),
	.synth_divider(synth_divider), .pll_ref_enable(pll_ref_enable),
	.queue_bypass(queue_bypass), .char_width_8(char_width_8));

// ---- verif/sxmc_serial_model.sv ----
`timescale 1ns/1ps

module sxmc_serial_model
	import sxmc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              hold,
	input  wire logic [CHAR_W-1:0] enc_char,
	input  wire logic              enc_type,
	input  wire logic              enc_valid,
	output logic                   enc_ready
);
	logic [CHAR_W:0] got [$];

	// Random stall; hold freezes it so the buffer can fill up
	always @(posedge clk)
	begin
		if (enc_valid && enc_ready)
			got.push_back({enc_type, enc_char});
		enc_ready <= hold ? 1'b0 : 1'($urandom);
	end
endmodule
